// ### rtl/rac_defines.vh
// Register map, field positions, reset values and timing constants
`ifndef RAC_DEFINES_VH
`define RAC_DEFINES_VH

// ==========================================================
// Register indices; byte address is four times the index
`define RAC_IDX_RADIO_CTRL2 8'h0c
`define RAC_IDX_ANTENNA_DIVERSITY_REGISTER 8'h0d
`define RAC_IDX_RX_THRESH 8'h15
`define RAC_IDX_EXT_CTRL1 8'h17
`define RAC_IDX_STATUS 8'h20

// ==========================================================
// radio_control_two fields
`define RAC_RATE_LSB 0
`define RAC_RATE_MSB 2
`define RAC_SCRAM_BIT 5
`define RAC_SAFE_BIT 7
`define RAC_RC2_RESET 8'h20
`define RAC_RC2_MASK 8'ha7

// Payload rate codes
`define RAC_RATE_250K 3'h0
`define RAC_RATE_500K 3'h1
`define RAC_RATE_1000K 3'h2
`define RAC_RATE_2000K 3'h3

// ==========================================================
// receive_threshold fields
`define RAC_LEVEL_LSB 0
`define RAC_LEVEL_MSB 3
`define RAC_BLOCK_BIT 7
`define RAC_RXT_RESET 8'h00
`define RAC_RXT_MASK 8'h8f

// ==========================================================
// extended_mode_control_one fields
`define RAC_ACKTIME_BIT 2
`define RAC_EXT_RESET 8'h00
`define RAC_EXT_MASK 8'hf7

// ==========================================================
// antenna_diversity_register fields
`define RAC_ANTCTRL_LSB 0
`define RAC_ANTCTRL_MSB 1
`define RAC_SWEN_BIT 2
`define RAC_DIVEN_BIT 3
`define RAC_ANTSEL_BIT 7
`define RAC_ANT_RESET 8'h00
`define RAC_ANT_MASK 8'h0f

// ==========================================================
// Timing: clock rate and acknowledgment turnaround
`define RAC_CLK_MHZ 100
`define RAC_ACK_LONG_US 192
`define RAC_ACK_SHORT_US 32
`define RAC_ACK_LONG_CYC (`RAC_ACK_LONG_US * `RAC_CLK_MHZ)
`define RAC_ACK_SHORT_CYC (`RAC_ACK_SHORT_US * `RAC_CLK_MHZ)
`define RAC_DWELL_CYC 64

`endif

// ### rtl/rac_ack_timer.v
// Acknowledgment turnaround down-counter with start pulse
`include "rac_defines.vh"

module rac_ack_timer
#(
  parameter CNT_W = 15,
  parameter [14:0] LONG_CYC = `RAC_ACK_LONG_CYC,
  parameter [14:0] SHORT_CYC = `RAC_ACK_SHORT_CYC
)
(
  input wire ref_clk, // System clock
  input wire rst_n, // Synchronous reset, active low
  input wire arm, // Frame end needing an ack
  input wire short_sel, // Short turnaround chosen
  input wire abort, // Leave the auto-ack mode
  output wire busy, // Turnaround running
  output reg fire // One-cycle start of ack
);

  reg [CNT_W-1:0] cnt_r;
  reg [CNT_W-1:0] cnt_nxt;
  reg fire_nxt;

  assign busy = (cnt_r != {CNT_W{1'b0}});

  // ==========================================================
  // Countdown; fires as the count steps from one to zero
  always @*
  begin
    cnt_nxt = cnt_r;
    fire_nxt = 1'b0;
    if (abort)
      cnt_nxt = {CNT_W{1'b0}};
    else if (arm)
      cnt_nxt = short_sel ? SHORT_CYC : LONG_CYC;
    else if (busy)
    begin
      cnt_nxt = cnt_r - {{(CNT_W-1){1'b0}}, 1'b1};
      fire_nxt = (cnt_r == {{(CNT_W-1){1'b0}}, 1'b1});
    end
  end

  // ==========================================================
  // State flops
  always @(posedge ref_clk)
  begin
    if (!rst_n)
    begin
      cnt_r <= {CNT_W{1'b0}};
      fire <= 1'b0;
    end
    else
    begin
      cnt_r <= cnt_nxt;
      fire <= fire_nxt;
    end
  end

endmodule // rac_ack_timer

// ### rtl/rac_top.v
// Rate, acknowledgment and antenna control block with Avalon-MM slave
//
// Implementation choice: the Avalon-MM slave port.
`include "rac_defines.vh"

module rac_top
#(
  parameter [14:0] ACK_LONG_CYC = `RAC_ACK_LONG_CYC,
  parameter [14:0] ACK_SHORT_CYC = `RAC_ACK_SHORT_CYC,
  parameter [7:0] DWELL_CYC = `RAC_DWELL_CYC
)
(
  input wire ref_clk, // System clock, 100 MHz
  input wire rst_n, // Synchronous reset, active low
  input wire [7:0] avs_address, // Byte address
  input wire avs_read, // Read request
  input wire avs_write, // Write request
  input wire [31:0] avs_writedata, // Write data
  output reg [31:0] avs_readdata, // Read data
  output wire avs_waitrequest, // Stall the master
  input wire auto_ack_receive_mode, // Auto-ack receive state
  input wire rx_active, // Receiver in a receive state
  input wire rx_shr_found, // Pulse: header detected
  input wire [3:0] rx_rssi_steps, // RSSI above floor, 3dB units
  input wire rx_in_psdu, // Payload octets on air
  input wire rx_frame_end, // Pulse: last symbol received
  input wire rx_ack_request, // Frame asks for an ack
  output wire ack_tx_start, // Pulse: begin ack frame
  output reg frame_accept, // Pulse: frame passed threshold
  output reg frame_reject, // Pulse: frame dropped
  output wire [2:0] payload_rate_select, // Programmed rate
  output reg [2:0] active_rate, // Rate now on air
  output reg chip_scramble_on, // Scrambling applied
  output wire [3:0] rx_desense_level, // Threshold level
  output wire rx_path_block, // Receiver path blocked
  output wire rx_safe_mode, // Receive safe mode bit
  output reg antenna_select, // Antenna in use
  output reg switch_output_a_o, // Switch pin A level
  output reg switch_output_a_oe, // Switch pin A enable
  output reg switch_output_b_o, // Switch pin B level
  output reg switch_output_b_oe // Switch pin B enable
);

  // ==========================================================
  // Diversity states
  localparam [2:0] ST_IDLE = 3'b001;
  localparam [2:0] ST_SEARCH = 3'b010;
  localparam [2:0] ST_LOCK = 3'b100;

  reg [7:0] rc2_r;
  reg [7:0] rxt_r;
  reg [7:0] ext_r;
  reg [7:0] ant_r;
  reg ack_r;
  reg [2:0] st_r;
  reg [2:0] st_nxt;
  reg [7:0] dwell_r;
  reg [7:0] dwell_nxt;
  reg srch_ant_r;
  reg srch_ant_nxt;
  reg sel_ant_r;
  reg sel_ant_nxt;
  reg [7:0] rd_byte;
  reg hit;
  reg static_ant;
  wire req;
  wire take;
  wire [5:0] idx;
  wire wr_ok;
  wire div_en;
  wire sw_en;
  wire pass;
  wire ack_busy;
  wire [7:0] wbyte;

  // ==========================================================
  // Bus slave: one wait state, then the access completes
  assign req = avs_read | avs_write;
  assign avs_waitrequest = req & ~ack_r;
  assign take = req & ack_r;
  assign idx = avs_address[7:2];
  assign wr_ok = avs_write & take & (avs_address[1:0] == 2'b00);
  assign wbyte = avs_writedata[7:0];

  // Wait-state flop, cleared after each completed access
  always @(posedge ref_clk)
  begin
    if (!rst_n)
      ack_r <= 1'b0;
    else
      ack_r <= req & ~ack_r;
  end

  // ==========================================================
  // Field views of the control registers
  assign payload_rate_select = rc2_r[`RAC_RATE_MSB:`RAC_RATE_LSB];
  assign rx_desense_level = rxt_r[`RAC_LEVEL_MSB:`RAC_LEVEL_LSB];
  assign rx_path_block = rxt_r[`RAC_BLOCK_BIT];
  assign rx_safe_mode = rc2_r[`RAC_SAFE_BIT];
  assign div_en = ant_r[`RAC_DIVEN_BIT];
  assign sw_en = ant_r[`RAC_SWEN_BIT];

  // ==========================================================
  // Register writes; reserved bits are masked off
  always @(posedge ref_clk)
  begin
    if (!rst_n)
    begin
      rc2_r <= `RAC_RC2_RESET;
      rxt_r <= `RAC_RXT_RESET;
      ext_r <= `RAC_EXT_RESET;
      ant_r <= `RAC_ANT_RESET;
    end
    else if (wr_ok)
    begin
      case (idx)
        `RAC_IDX_RADIO_CTRL2:
        begin
          // Reserved rate codes keep the previous rate
          if (wbyte[`RAC_RATE_MSB:`RAC_RATE_LSB] <= `RAC_RATE_2000K)
            rc2_r <= wbyte & `RAC_RC2_MASK;
          else
            rc2_r <= (wbyte & `RAC_RC2_MASK & 8'hf8) |
                     (rc2_r & 8'h07);
        end
        `RAC_IDX_RX_THRESH:
          rxt_r <= wbyte & `RAC_RXT_MASK;
        `RAC_IDX_EXT_CTRL1:
          ext_r <= wbyte & `RAC_EXT_MASK;
        `RAC_IDX_ANTENNA_DIVERSITY_REGISTER:
          ant_r <= wbyte & `RAC_ANT_MASK;
        default:
          rc2_r <= rc2_r;
      endcase
    end
  end

  // ==========================================================
  // Read mux; unmapped addresses return zero
  always @*
  begin
    case (idx)
      `RAC_IDX_RADIO_CTRL2: rd_byte = rc2_r;
      `RAC_IDX_RX_THRESH: rd_byte = rxt_r;
      `RAC_IDX_EXT_CTRL1: rd_byte = ext_r;
      `RAC_IDX_ANTENNA_DIVERSITY_REGISTER: rd_byte = {sel_ant_r, 3'h0, ant_r[3:0]};
      `RAC_IDX_STATUS: rd_byte = {4'h0, chip_scramble_on,
                                  ack_busy, st_r == ST_LOCK,
                                  antenna_select};
      default: rd_byte = 8'h00;
    endcase
    if (avs_address[1:0] != 2'b00)
      rd_byte = 8'h00;
  end

  // Read data captured on the wait-state edge, stable when taken
  always @(posedge ref_clk)
  begin
    if (!rst_n)
      avs_readdata <= 32'h0000_0000;
    else if (avs_read & ~ack_r)
      avs_readdata <= {24'h00_0000, rd_byte};
  end

  // ==========================================================
  // Acknowledgment turnaround, only in auto-ack receive mode
  rac_ack_timer
  #(
    .CNT_W(15),
    .LONG_CYC(ACK_LONG_CYC),
    .SHORT_CYC(ACK_SHORT_CYC)
  )
  u_ack_timer
  (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .arm(auto_ack_receive_mode & rx_frame_end & rx_ack_request),
    .short_sel(ext_r[`RAC_ACKTIME_BIT]),
    .abort(~auto_ack_receive_mode),
    .busy(ack_busy),
    .fire(ack_tx_start)
  );

  // ==========================================================
  // Sensitivity threshold: level n needs RSSI of n steps or more
  assign pass = (rx_desense_level == 4'h0) |
                (rx_rssi_steps >= rx_desense_level);

  always @(posedge ref_clk)
  begin
    if (!rst_n)
    begin
      frame_accept <= 1'b0;
      frame_reject <= 1'b0;
    end
    else
    begin
      frame_accept <= rx_active & rx_shr_found & pass;
      frame_reject <= rx_active & rx_shr_found & ~pass;
    end
  end

  // ==========================================================
  // On-air rate: header at base rate, payload at chosen rate
  always @(posedge ref_clk)
  begin
    if (!rst_n)
    begin
      active_rate <= `RAC_RATE_250K;
      chip_scramble_on <= 1'b0;
    end
    else
    begin
      active_rate <= rx_in_psdu ? payload_rate_select
                                : `RAC_RATE_250K;
      chip_scramble_on <= rx_in_psdu & rc2_r[`RAC_SCRAM_BIT] &
        (payload_rate_select == `RAC_RATE_2000K);
    end
  end

  // ==========================================================
  // Static antenna choice when the search is disabled
  always @*
  begin
    case (ant_r[`RAC_ANTCTRL_MSB:`RAC_ANTCTRL_LSB])
      2'h2: static_ant = 1'b1;
      default: static_ant = 1'b0;
    endcase
  end

  // ==========================================================
  // Diversity search; independent of rate and operating mode
  always @*
  begin
    st_nxt = st_r;
    dwell_nxt = dwell_r;
    srch_ant_nxt = srch_ant_r;
    sel_ant_nxt = sel_ant_r;
    hit = rx_shr_found & pass;
    case (st_r)
      ST_IDLE:
      begin
        dwell_nxt = 8'h00;
        if (div_en & rx_active)
          st_nxt = ST_SEARCH;
      end
      ST_SEARCH:
      begin
        if (~div_en | ~rx_active)
          st_nxt = ST_IDLE;
        else if (hit)
        begin
          st_nxt = ST_LOCK;
          sel_ant_nxt = srch_ant_r;
        end
        else if (dwell_r >= DWELL_CYC - 8'h01)
        begin
          dwell_nxt = 8'h00;
          srch_ant_nxt = ~srch_ant_r;
        end
        else
          dwell_nxt = dwell_r + 8'h01;
      end
      ST_LOCK:
      begin
        // Hold through the frame; rx_frame_end returns to the search before any ack starts
        if (~div_en | ~rx_active)
          st_nxt = ST_IDLE;
        else if (rx_frame_end)
        begin
          st_nxt = ST_SEARCH;
          dwell_nxt = 8'h00;
        end
      end
      default:
        st_nxt = ST_IDLE;
    endcase
  end

  // Search state flops; last locked antenna stays readable while diversity is enabled, else the static choice
  always @(posedge ref_clk)
  begin
    if (!rst_n)
    begin
      st_r <= ST_IDLE;
      dwell_r <= 8'h00;
      srch_ant_r <= 1'b0;
      sel_ant_r <= 1'b0;
    end
    else
    begin
      st_r <= st_nxt;
      dwell_r <= dwell_nxt;
      srch_ant_r <= srch_ant_nxt;
      sel_ant_r <= div_en ? sel_ant_nxt : static_ant;
    end
  end

  // ==========================================================
  // Antenna in use and differential switch drive
  always @(posedge ref_clk)
  begin
    if (!rst_n)
    begin
      antenna_select <= 1'b0;
      switch_output_a_o <= 1'b0;
      switch_output_a_oe <= 1'b0;
      switch_output_b_o <= 1'b0;
      switch_output_b_oe <= 1'b0;
    end
    else
    begin
      if (!div_en)
        antenna_select <= static_ant;
      else if (st_r == ST_LOCK)
        antenna_select <= sel_ant_r;
      else
        antenna_select <= srch_ant_r;
      // Disabled pins are released so the board pull-down wins
      switch_output_a_oe <= sw_en;
      switch_output_b_oe <= sw_en;
      switch_output_a_o <= sw_en & antenna_select;
      switch_output_b_o <= sw_en & ~antenna_select;
    end
  end

endmodule // rac_top

// ### testbench/rac_top_asserts.sv
// Checker for the rate, acknowledgment and antenna control block
module rac_top_asserts
#(
  parameter [14:0] ACK_LONG_CYC = 15'h0028,
  parameter [14:0] ACK_SHORT_CYC = 15'h0008,
  parameter [7:0] DWELL_CYC = 8'h04
)
(
  input wire ref_clk, // Clock
  input wire rst_n, // Reset, active low
  input wire avs_read, // Read request
  input wire avs_write, // Write request
  input wire [31:0] avs_readdata, // Read data
  input wire avs_waitrequest, // Stall
  input wire auto_ack_receive_mode, // Auto-ack state
  input wire rx_active, // Receiving
  input wire rx_shr_found, // Header pulse
  input wire [3:0] rx_rssi_steps, // Strength
  input wire rx_in_psdu, // Payload on air
  input wire rx_frame_end, // Frame end pulse
  input wire rx_ack_request, // Ack wanted
  input wire ack_tx_start, // Ack start pulse
  input wire frame_accept, // Accept pulse
  input wire frame_reject, // Reject pulse
  input wire [2:0] payload_rate_select, // Rate code
  input wire [2:0] active_rate, // Rate on air
  input wire chip_scramble_on, // Scrambling
  input wire [3:0] rx_desense_level, // Threshold
  input wire antenna_select, // Antenna
  input wire switch_output_a_o, // Pin A level
  input wire switch_output_a_oe, // Pin A enable
  input wire switch_output_b_o, // Pin B level
  input wire switch_output_b_oe // Pin B enable
);
  localparam int L = ACK_LONG_CYC;
  localparam int S = ACK_SHORT_CYC;
  logic [15:0] cnt_r;
  logic lost_r;
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!rst_n);

  // ==========================================================
  // Edges since the last arm; the pulse has a one-edge margin
  always @(posedge ref_clk)
  begin
    if (!rst_n || (auto_ack_receive_mode && rx_frame_end && rx_ack_request))
    begin
      cnt_r <= {15'h0, rst_n};
      lost_r <= 1'b0;
    end
    else
    begin
      if (cnt_r != 16'h0 && cnt_r != 16'hffff)
        cnt_r <= cnt_r + 16'h1;
      if (!auto_ack_receive_mode)
        lost_r <= 1'b1;
    end
  end

  // ==========================================================
  // Assertions
  wait_once_a: assert property ((avs_read || avs_write) && avs_waitrequest // -
    |=> !avs_waitrequest) else $error("wait state not one cycle");
  rd_upper_a: assert property (avs_readdata[31:8] == 24'h0)
    else $error("read data upper bits set");
  ack_delay_a: assert property (ack_tx_start |-> cnt_r == L + 1 ||
    cnt_r == L + 2 || cnt_r == S + 1 || cnt_r == S + 2)
    else $error("ack turnaround wrong");
  ack_mode_a: assert property (ack_tx_start |-> !lost_r && cnt_r != 0)
    else $error("ack outside auto-ack mode");
  hdr_rate_a: assert property (!$past(rx_in_psdu) |-> active_rate == 3'h0)
    else $error("header not at base rate");
  psdu_rate_a: assert property ($past(rx_in_psdu) && $past(rst_n)
    |-> active_rate == $past(payload_rate_select))
    else $error("payload rate wrong");
  scram_rate_a: assert property (chip_scramble_on |-> active_rate == 3'h3)
    else $error("scrambling off top rate");
  thresh_pick_a: assert property (frame_accept || frame_reject |->
    $past(rx_shr_found) && frame_accept == ($past(rx_desense_level) == 0 ||
    $past(rx_rssi_steps) >= $past(rx_desense_level)))
    else $error("threshold decision wrong");
  sw_diff_a: assert property (switch_output_a_oe |-> switch_output_b_oe &&
    switch_output_b_o != switch_output_a_o) else $error("pins not differential");
  sw_lag_a: assert property ($past(rst_n) && switch_output_a_oe |->
    switch_output_a_o == $past(antenna_select)) else $error("pin A wrong");
  sw_off_a: assert property (!switch_output_a_oe |-> !switch_output_a_o &&
    !switch_output_b_o) else $error("released pins driven");
  ack_c: cover property (ack_tx_start);
  reject_c: cover property (frame_reject);
  scram_c: cover property (chip_scramble_on);
  sw_c: cover property (switch_output_a_oe && switch_output_a_o);
endmodule // rac_top_asserts

bind rac_top rac_top_asserts #(.ACK_LONG_CYC(ACK_LONG_CYC),
  .ACK_SHORT_CYC(ACK_SHORT_CYC), .DWELL_CYC(DWELL_CYC)) i_rac_top_asserts (
  .ref_clk, .rst_n, .avs_read, .avs_write, .avs_readdata, .avs_waitrequest,
  .auto_ack_receive_mode, .rx_active, .rx_shr_found, .rx_rssi_steps,
  .rx_in_psdu, .rx_frame_end, .rx_ack_request, .ack_tx_start, .frame_accept,
  .frame_reject, .payload_rate_select, .active_rate, .chip_scramble_on,
  .rx_desense_level, .antenna_select, .switch_output_a_o,
  .switch_output_a_oe, .switch_output_b_o, .switch_output_b_oe);

// ### testbench/rac_radio_model.sv
// Remote radio nodes and external antenna switch model
module rac_radio_model
(
  input wire ref_clk, // Clock
  input wire a_o, // Pin A level
  input wire a_oe, // Pin A enable
  input wire b_o, // Pin B level
  input wire b_oe, // Pin B enable
  output logic shr = 1'b0, // Header pulse
  output logic [3:0] rssi = 4'h0, // Strength
  output logic psdu = 1'b0, // Payload on air
  output logic fend = 1'b0, // Frame end pulse
  output logic areq = 1'b0, // Ack wanted
  output wire sw_a, // Switch input A
  output wire sw_b // Switch input B
);
  // Released pins fall to the pull-down
  assign sw_a = a_oe ? a_o : 1'b0;
  assign sw_b = b_oe ? b_o : 1'b0;

  // ==========================================================
  // One frame; qualifiers change once their sample edge is over
  task automatic send_frame(input logic [3:0] r, input logic req, input int n);
    @(posedge ref_clk);
    shr <= 1'b1;
    rssi <= r;
    @(posedge ref_clk);
    shr <= 1'b0;
    rssi <= ~r;
    repeat (2) @(posedge ref_clk);
    psdu <= 1'b1;
    repeat (n) @(posedge ref_clk);
    psdu <= 1'b0;
    fend <= 1'b1;
    areq <= req;
    @(posedge ref_clk);
    fend <= 1'b0;
    areq <= ~req;
  endtask
endmodule // rac_radio_model

// ### testbench/rac_tb_top.sv
// Self-checking bench for the rate, ack and antenna control block
module rac_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int LONG = 40;
  localparam int SHORT = 8;
  localparam int DWELL = 4;
  logic ref_clk = 1'b0;
  logic rst_n = 1'b0;
  logic [7:0] avs_address = 8'h00;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic mode = 1'b0;
  logic rx_active = 1'b0;
  wire [31:0] rdata;
  wire wreq, shr, psdu, fend, areq, ack, acc, rej, scram, blk, safe, ant;
  wire ao, aoe, bo, boe, sw_a, sw_b;
  wire [3:0] rssi, lvl;
  wire [2:0] prs, arate;
  logic [7:0] exp_q[$];
  int ack_q[$];
  logic acc_q[$];
  int num_errors = 0;
  int cmp_count = 0;
  int tg, seed;
  time t_arm;
  logic pa;
  logic [7:0] d, r;

  rac_top #(.ACK_LONG_CYC(15'd40), .ACK_SHORT_CYC(15'd8), .DWELL_CYC(8'd4))
  i_rac_top (.ref_clk(ref_clk), .rst_n(rst_n), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_readdata(rdata), .avs_waitrequest(wreq),
    .auto_ack_receive_mode(mode), .rx_active(rx_active), .rx_shr_found(shr),
    .rx_rssi_steps(rssi), .rx_in_psdu(psdu), .rx_frame_end(fend),
    .rx_ack_request(areq), .ack_tx_start(ack), .frame_accept(acc),
    .frame_reject(rej), .payload_rate_select(prs), .active_rate(arate),
    .chip_scramble_on(scram), .rx_desense_level(lvl), .rx_path_block(blk),
    .rx_safe_mode(safe), .antenna_select(ant), .switch_output_a_o(ao),
    .switch_output_a_oe(aoe), .switch_output_b_o(bo),
    .switch_output_b_oe(boe));
  rac_radio_model i_rac_radio_model (.ref_clk(ref_clk), .a_o(ao),
    .a_oe(aoe), .b_o(bo), .b_oe(boe), .shr(shr), .rssi(rssi), .psdu(psdu),
    .fend(fend), .areq(areq), .sw_a(sw_a), .sw_b(sw_b));

  // ==========================================================
  // Clock, compare, verdict and bus master
  initial
  begin
    forever #5 ref_clk = ~ref_clk;
  end
  task automatic check(input string n, input logic [31:0] s, input logic [31:0] e);
    cmp_count++;
    if (s !== e)
    begin
      num_errors++;
      $display("Error %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic finish_test;
    if (num_errors == 0 && cmp_count > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  // Request held until the edge that samples waitrequest low
  task automatic bus(input logic wr, input logic [7:0] a, input logic [7:0] v);
    @(posedge ref_clk);
    avs_address <= a;
    avs_read <= !wr;
    avs_write <= wr;
    avs_writedata <= {24'h0, v};
    if (!wr)
      exp_q.push_back(v);
    do @(posedge ref_clk); while (wreq !== 1'b0);
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask

  // ==========================================================
  // Monitors take the oldest note when a result shows
  always @(posedge ref_clk)
  begin
    if (avs_read && wreq === 1'b0)
      check("readdata", rdata, {24'h0, exp_q.pop_front()});
    if (acc === 1'b1 || rej === 1'b1)
      check("accept", acc, acc_q.pop_front());
    if (mode && fend && areq)
      t_arm = $time;
    if (ack === 1'b1)
      if (ack_q.size() == 0)
        check("ack_unarmed", 1'b1, 1'b0);
      else
        check("ack_delay", ($time - t_arm) / 10 - ack_q.pop_front() inside
          {1, 2}, 1'b1);
  end
  initial
  begin
    #60us;
    num_errors++;
    finish_test();
  end
  // Frame with a payload probe partway in
  task automatic frame_probe(input logic s);
    acc_q.push_back(d[3:0] == 4'h0);
    fork
      i_rac_radio_model.send_frame(4'h0, 1'b0, 6);
      begin
        wait (psdu === 1'b1);
        repeat (2) @(posedge ref_clk);
        #1 check("active_rate", arate, 3'h3);
        check("scramble", scram, s);
      end
    join
  endtask
  task automatic count_toggles(input int n);
    tg = 0;
    pa = ant;
    repeat (n)
    begin
      @(posedge ref_clk);
      tg += (ant !== pa);
      pa = ant;
    end
  endtask

  // ==========================================================
  // Main sequence
  initial
  begin
    seed = $urandom(32'h1b33);
    repeat (8) @(posedge ref_clk);
    rst_n <= 1'b1;
    rx_active <= 1'b1;
    bus(0, 8'h30, 8'h20);
    bus(0, 8'h54, 8'h00);
    bus(0, 8'h5c, 8'h00);
    bus(0, 8'h34, 8'h00);
    bus(0, 8'h80, 8'h00);
    // Every rate code; reserved codes and bits leave no trace
    r = 8'h0;
    for (int c = 0; c < 8; c++)
    begin
      bus(1, 8'h30, 8'h58 | {c[0], 4'h0, c[2:0]});
      r = {c[0], 4'h0, (c < 4) ? c[2:0] : r[2:0]};
      bus(0, 8'h30, r);
      check("rate_field", {safe, prs}, {r[7], r[2:0]});
    end
    d = $urandom();
    bus(1, 8'h54, d);
    bus(0, 8'h54, d & 8'h8f);
    check("receive_threshold_fields", {blk, lvl}, {d[7], d[3:0]});
    bus(1, 8'h5c, d);
    bus(0, 8'h5c, d & 8'hf7);
    bus(1, 8'h40, d);
    bus(0, 8'h40, 8'h00);
    bus(0, 8'h31, 8'h00);
    // Scrambling only with its bit at the top rate
    for (int s = 1; s >= 0; s--)
    begin
      bus(1, 8'h30, {2'b00, s[0], 5'h03});
      frame_probe(s[0]);
    end
    // Threshold either side of a random level, then level zero
    d = 8'h1 + $urandom_range(14);
    bus(1, 8'h54, d);
    for (int k = 0; k < 3; k++)
    begin
      if (k == 2)
        bus(1, 8'h54, 8'h00);
      acc_q.push_back(k != 0);
      i_rac_radio_model.send_frame(k == 0 ? d - 1 : (k == 1 ? d : 0), 0, 2);
    end
    // Both turnarounds, then leaving the mode mid count
    mode <= 1'b1;
    for (int s = 0; s < 3; s++)
    begin
      bus(1, 8'h5c, {5'h0, s == 1, 2'b00});
      if (s < 2)
        ack_q.push_back(s ? SHORT : LONG);
      acc_q.push_back(1'b1);
      i_rac_radio_model.send_frame(4'h0, 1'b1, 2);
      if (s == 2)
        mode <= 1'b0;
      repeat (LONG + 8) @(posedge ref_clk);
    end
    // Static antenna choice on the switch pins, then released
    bus(1, 8'h34, 8'h06);
    repeat (3) @(posedge ref_clk);
    check("sw_ant1", {sw_a, sw_b}, 2'b10);
    bus(1, 8'h34, 8'h05);
    repeat (3) @(posedge ref_clk);
    check("sw_ant0", {sw_a, sw_b, aoe}, 3'b011);
    bus(1, 8'h34, 8'h00);
    repeat (3) @(posedge ref_clk);
    check("sw_off", {sw_a, sw_b, aoe}, 3'b000);
    // Search alternates, a found frame locks, then search resumes
    bus(1, 8'h34, 8'h0c);
    count_toggles(4 * DWELL + 4);
    check("search", tg >= 2, 1'b1);
    acc_q.push_back(1'b1);
    fork
      i_rac_radio_model.send_frame(4'h0, 1'b0, 5 * DWELL);
      begin
        @(posedge ref_clk iff shr);
        repeat (3) @(posedge ref_clk);
        count_toggles(4 * DWELL);
        check("locked", tg, 0);
      end
    join
    count_toggles(4 * DWELL);
    check("resume", tg >= 2, 1'b1);
    check("notes_left", exp_q.size() + ack_q.size() + acc_q.size(), 0);
    finish_test();
  end
endmodule // rac_tb_top
